// file: rtl/agp_host.sv
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
// Controller end: power-up sequence and register access
module agp_host
  import agp_pkg::*;
#(
  parameter int POR_CYCLES = POWER_ON_WAIT_CYCLES, // Wait after clock start
  parameter int RST_CYCLES = RESET_LOW_CYCLES      // Reset low width
)(
  input  wire logic        hclk,       // Clock
  input  wire logic        hresetn,    // Async reset, active low
  input  wire logic        hsel,       // Slave select
  input  wire logic [31:0] haddr,      // Address
  input  wire logic [1:0]  htrans,     // Transfer type
  input  wire logic        hwrite,     // Write
  input  wire logic [2:0]  hsize,      // Size, word only
  input  wire logic [31:0] hwdata,     // Write data
  input  wire logic        hready,     // Bus ready
  output logic             hreadyout,  // Slave ready
  output logic             hresp,      // Response, always OKAY
  output logic      [31:0] hrdata,     // Read data
  input  wire logic        supply_ok,  // Supplies settled
  agp_link_if.host         link        // Converter side
);
  typedef enum logic [2:0] {HS_OFF, HS_POR, HS_RST, HS_CFG, HS_IDLE, HS_WAIT} agp_state_e;

  agp_state_e  st_reg, st_next;
  logic [31:0] cnt_reg, cnt_next;
  logic        clk_reg, clk_next, rstn_reg, rstn_next;
  logic        wr_reg, wr_next, rd_reg, rd_next;
  logic [7:0]  addr_reg, addr_next, wdat_reg, wdat_next;
  logic [7:0]  rdat_reg, rdat_next;
  logic        ready_reg, ready_next;
  logic        start_reg, start_next;
  logic [7:0]  cfg_reg, cfg_next;
  logic        pend_reg, pend_next;
  logic [16:0] cmd_reg, cmd_next;
  logic        sup_s1_reg, sup_s2_reg;
  logic        ap_reg, ap_next, apw_reg, apw_next;
  logic [7:0]  apa_reg, apa_next;
  logic [31:0] hrdata_next;
  logic        ap_take;

  assign ap_take = hsel && hready && htrans[1];

  // Bus slave: address phase capture, data phase write, read mux
  always_comb
  begin
    ap_next     = ap_take;
    apw_next    = hwrite;
    apa_next    = haddr[7:0];
    start_next  = start_reg;
    cfg_next    = cfg_reg;
    hrdata_next = hrdata;
    if (ap_reg && apw_reg)
    begin
      if (apa_reg == HOST_CTRL_OFF)
      begin
        start_next = hwdata[CTRL_START_BIT];
        cfg_next   = hwdata[CTRL_CFG_LSB +: 8];
      end
    end
    if (ap_take && !hwrite)
    begin
      hrdata_next = 32'h0;
      case (haddr[7:0])
        HOST_CTRL_OFF: hrdata_next = {16'h0, cfg_next, 7'h0, start_next};
        HOST_CMD_OFF:  hrdata_next = {15'h0, cmd_reg};
        HOST_STAT_OFF: hrdata_next = {16'h0, rdat_next, 5'h0, sup_s2_reg,
                                      pend_next || st_next != HS_IDLE, ready_next};
        default:       hrdata_next = 32'h0;
      endcase
    end
  end

  // Sequencer and link access
  always_comb
  begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    clk_next   = clk_reg;
    rstn_next  = rstn_reg;
    wr_next    = 1'b0;
    rd_next    = 1'b0;
    addr_next  = addr_reg;
    wdat_next  = wdat_reg;
    rdat_next  = rdat_reg;
    ready_next = ready_reg;
    pend_next  = pend_reg;
    cmd_next   = cmd_reg;
    // Command taken only when idle and nothing pending
    if (ap_reg && apw_reg && apa_reg == HOST_CMD_OFF && st_reg == HS_IDLE && !pend_reg)
    begin
      cmd_next  = hwdata[16:0];
      pend_next = 1'b1;
    end
    case (st_reg)
      HS_OFF:
      begin
        clk_next   = 1'b0;
        rstn_next  = 1'b0;
        ready_next = 1'b0;
        pend_next  = 1'b0;
        cnt_next   = 32'h0;
        if (sup_s2_reg && start_reg)
        begin
          clk_next  = 1'b1;
          rstn_next = 1'b1;
          st_next   = HS_POR;
        end
      end
      HS_POR:
      begin
        cnt_next = cnt_reg + 32'h1;
        if (cnt_reg == 32'(POR_CYCLES - 1))
        begin
          cnt_next  = 32'h0;
          rstn_next = 1'b0;
          st_next   = HS_RST;
        end
      end
      HS_RST:
      begin
        cnt_next = cnt_reg + 32'h1;
        if (cnt_reg == 32'(RST_CYCLES - 1))
        begin
          rstn_next = 1'b1;
          st_next   = HS_CFG;
        end
      end
      HS_CFG:
      begin
        wr_next    = 1'b1;
        addr_next  = CONFIG1_OFF;
        wdat_next  = cfg_reg;
        ready_next = 1'b1;
        st_next    = HS_IDLE;
      end
      HS_IDLE:
      begin
        if (pend_reg)
        begin
          pend_next = 1'b0;
          addr_next = cmd_reg[CMD_ADDR_LSB +: 8];
          wdat_next = cmd_reg[CMD_DATA_LSB +: 8];
          if (cmd_reg[CMD_WRITE_BIT])
            wr_next = 1'b1;
          else
          begin
            rd_next = 1'b1;
            st_next = HS_WAIT;
          end
        end
      end
      HS_WAIT:
      begin
        if (link.reg_rvalid)
        begin
          rdat_next = link.reg_rdata;
          st_next   = HS_IDLE;
        end
      end
      default: st_next = HS_OFF;
    endcase
    if (!start_reg || !sup_s2_reg)
    begin
      st_next   = HS_OFF;
      clk_next  = 1'b0;
      rstn_next = 1'b0;
      wr_next   = 1'b0;
      rd_next   = 1'b0;
    end
    if ((wr_next || rd_next) && addr_next == PIN_IO_CONTROL_OFF)
      wdat_next[7:4] = UPPER_ZERO;
  end

  // State registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg     <= HS_OFF;
      cnt_reg    <= 32'h0;
      clk_reg    <= 1'b0;
      rstn_reg   <= 1'b0;
      wr_reg     <= 1'b0;
      rd_reg     <= 1'b0;
      addr_reg   <= 8'h00;
      wdat_reg   <= 8'h00;
      rdat_reg   <= 8'h00;
      ready_reg  <= 1'b0;
      start_reg  <= 1'b0;
      cfg_reg    <= CFG_RESET;
      pend_reg   <= 1'b0;
      cmd_reg    <= 17'h0;
      sup_s1_reg <= 1'b0;
      sup_s2_reg <= 1'b0;
      ap_reg     <= 1'b0;
      apw_reg    <= 1'b0;
      apa_reg    <= 8'h00;
      hrdata     <= 32'h0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
    else
    begin
      st_reg     <= st_next;
      cnt_reg    <= cnt_next;
      clk_reg    <= clk_next;
      rstn_reg   <= rstn_next;
      wr_reg     <= wr_next;
      rd_reg     <= rd_next;
      addr_reg   <= addr_next;
      wdat_reg   <= wdat_next;
      rdat_reg   <= rdat_next;
      ready_reg  <= ready_next;
      start_reg  <= start_next;
      cfg_reg    <= cfg_next;
      pend_reg   <= pend_next;
      cmd_reg    <= cmd_next;
      sup_s1_reg <= supply_ok;
      sup_s2_reg <= sup_s1_reg;
      ap_reg     <= ap_next;
      apw_reg    <= apw_next;
      apa_reg    <= apa_next;
      hrdata     <= hrdata_next;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
  end

  assign link.clk_run   = clk_reg;
  assign link.rst_n     = rstn_reg;
  assign link.reg_wr    = wr_reg;
  assign link.reg_rd    = rd_reg;
  assign link.reg_addr  = addr_reg;
  assign link.reg_wdata = wdat_reg;
endmodule // agp_host

// file: rtl/agp_pkg.sv
// Function
// - Bits 3:2 set pin direction, input default
// - Bits 1:0 read back actual pin levels
// - Output pin drives written data bit
// - Writes to input pin data discarded
// - Respiration modes take pins from I/O
// - Host holds device inputs low before power; host lowers clock, reset and strobes only, address and data keep last value
// - Clock, then wait 4096 modulator periods
// - Reset low at least one modulator period
// - Program first configuration register after reset
package agp_pkg;
  // Device register map
  localparam logic [7:0]  PIN_IO_CONTROL_OFF = 8'h0b;
  localparam logic [7:0]  CONFIG1_OFF        = 8'h01;
  localparam int          DIR_LSB            = 2;
  localparam int          LEVEL_LSB          = 0;
  localparam logic [1:0]  DIR_RESET          = 2'h3;
  localparam logic [1:0]  LEVEL_RESET        = 2'h0;
  localparam logic [3:0]  UPPER_ZERO         = 4'h0;
  // Host register map on AHB-Lite
  localparam logic [7:0]  HOST_CTRL_OFF      = 8'h00;
  localparam logic [7:0]  HOST_CMD_OFF       = 8'h04;
  localparam logic [7:0]  HOST_STAT_OFF      = 8'h08;
  localparam int          CTRL_START_BIT     = 0;
  localparam int          CTRL_CFG_LSB       = 8;
  localparam int          CMD_DATA_LSB       = 0;
  localparam int          CMD_ADDR_LSB       = 8;
  localparam int          CMD_WRITE_BIT      = 16;
  localparam int          STAT_READY_BIT     = 0;
  localparam int          STAT_BUSY_BIT      = 1;
  localparam int          STAT_SUPPLY_BIT    = 2;
  localparam int          STAT_RDATA_LSB     = 8;
  localparam logic [7:0]  CFG_RESET          = 8'h02;
  // Timing
  localparam int          CLK_PERIOD_NS         = 4;
  localparam int          MOD_PERIOD_NS         = 16;
  localparam int          MOD_CYCLES            = MOD_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          POWER_ON_WAIT_MODS    = 4096;
  localparam int          POWER_ON_WAIT_CYCLES  = POWER_ON_WAIT_MODS * MOD_CYCLES;
  localparam int          RESET_LOW_MODS        = 1;
  localparam int          RESET_LOW_CYCLES      = RESET_LOW_MODS * MOD_CYCLES;
endpackage

// file: rtl/agp_link_if.sv
`timescale 1ns/10ps
// Pins between controller and converter, one clock
interface agp_link_if;
  logic       clk_run;      // Master clock running
  logic       rst_n;        // Reset pin, active low
  logic       reg_wr;       // Register write strobe
  logic       reg_rd;       // Register read strobe
  logic [7:0] reg_addr;     // Register address
  logic [7:0] reg_wdata;    // Write data
  logic [7:0] reg_rdata;    // Read data
  logic       reg_rvalid;   // Read data valid pulse

  modport dev  (input clk_run, rst_n, reg_wr, reg_rd, reg_addr, reg_wdata,
                output reg_rdata, reg_rvalid);
  modport host (output clk_run, rst_n, reg_wr, reg_rd, reg_addr, reg_wdata,
                input reg_rdata, reg_rvalid);
endinterface

// file: rtl/agp_dev.sv
`timescale 1ns/10ps
// Converter end: general-purpose pin register
module agp_dev
  import agp_pkg::*;
(
  input  wire logic       hclk,       // Clock
  input  wire logic       hresetn,    // Async reset, active low
  agp_link_if.dev         link,       // Controller side
  input  wire logic       resp_mode,  // Respiration mode owns pins
  input  wire logic [1:0] pin_in,     // Pin levels
  output logic      [1:0] pin_out,    // Pin drive values
  output logic      [1:0] pin_oe      // Pin drive enables
);
  logic [1:0] dir_reg, dir_next;
  logic [1:0] dat_reg, dat_next;
  logic [1:0] pin_s1_reg, pin_s2_reg;
  logic       resp_s1_reg, resp_s2_reg;
  logic [7:0] rdata_reg, rdata_next;
  logic       rvalid_reg, rvalid_next;
  logic [1:0] out_next, oe_next;

  // Next register state and pin drive
  always_comb
  begin
    dir_next    = dir_reg;
    dat_next    = dat_reg;
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    if (link.clk_run)
    begin
      if (!link.rst_n)
      begin
        dir_next = DIR_RESET;
        dat_next = LEVEL_RESET;
      end
      else
      begin
        if (link.reg_wr && link.reg_addr == PIN_IO_CONTROL_OFF)
        begin
          dir_next = link.reg_wdata[DIR_LSB +: 2];
          for (int i = 0; i < 2; i++)
          begin
            if (!dir_next[i])
              dat_next[i] = link.reg_wdata[LEVEL_LSB + i];
          end
        end
        if (link.reg_rd)
        begin
          rvalid_next = 1'b1;
          if (link.reg_addr == PIN_IO_CONTROL_OFF)
            rdata_next = {UPPER_ZERO, dir_reg, pin_s2_reg};
          else
            rdata_next = 8'h00;
        end
      end
    end
    out_next = dat_next;
    oe_next  = ~dir_next & {2{~resp_s2_reg}};
  end

  // Registers and synchronisers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dir_reg     <= DIR_RESET;
      dat_reg     <= LEVEL_RESET;
      pin_s1_reg  <= 2'h0;
      pin_s2_reg  <= 2'h0;
      resp_s1_reg <= 1'b0;
      resp_s2_reg <= 1'b0;
      rdata_reg   <= 8'h00;
      rvalid_reg  <= 1'b0;
      pin_out     <= 2'h0;
      pin_oe      <= 2'h0;
    end
    else
    begin
      dir_reg     <= dir_next;
      dat_reg     <= dat_next;
      pin_s1_reg  <= pin_in;
      pin_s2_reg  <= pin_s1_reg;
      resp_s1_reg <= resp_mode;
      resp_s2_reg <= resp_s1_reg;
      rdata_reg   <= rdata_next;
      rvalid_reg  <= rvalid_next;
      pin_out     <= out_next;
      pin_oe      <= oe_next;
    end
  end

  assign link.reg_rdata  = rdata_reg;
  assign link.reg_rvalid = rvalid_reg;
endmodule // agp_dev

// file: verification/agp_link_checker.sv
`timescale 1ns/10ps
// Watches the link pins between controller and converter
module agp_link_checker
  import agp_pkg::*;
#(
  parameter int POR_CYCLES = POWER_ON_WAIT_CYCLES, // Wait after clock start
  parameter int RST_CYCLES = RESET_LOW_CYCLES      // Reset low width
)(
  input wire logic       hclk,       // Clock
  input wire logic       hresetn,    // Async reset
  input wire logic       clk_run,    // Clock running
  input wire logic       rst_n,      // Reset pin
  input wire logic       reg_wr,     // Write strobe
  input wire logic       reg_rd,     // Read strobe
  input wire logic [7:0] reg_addr,   // Address
  input wire logic [7:0] reg_wdata,  // Write data
  input wire logic [7:0] reg_rdata,  // Read data
  input wire logic       reg_rvalid  // Read answer
);
  logic        rst_prev_reg;
  logic [15:0] level_cnt_reg;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Counts cycles the reset pin held its level with the clock running
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rst_prev_reg  <= 1'b0;
      level_cnt_reg <= 16'h0;
    end
    else
    begin
      rst_prev_reg  <= rst_n;
      level_cnt_reg <= (!clk_run || rst_n != rst_prev_reg) ? 16'h0 : level_cnt_reg + 16'h1;
    end
  end

  por_wait_a: assert property ($fell(rst_n) && clk_run |-> level_cnt_reg >= POR_CYCLES - 1)
    else $error("reset pulse too soon after clock start");
  rst_width_a: assert property ($rose(rst_n) && clk_run && $past(clk_run)
    |-> level_cnt_reg >= RST_CYCLES - 1)
    else $error("reset pulse too short");
  cfg_write_a: assert property ($rose(rst_n) && clk_run && $past(clk_run)
    |-> !reg_wr ##1 (reg_wr && reg_addr == CONFIG1_OFF))
    else $error("config write missing after reset");
  idle_low_a: assert property (!clk_run |-> !rst_n && !reg_wr && !reg_rd)
    else $error("link input high without clock");
  rd_answer_a: assert property (reg_rd && clk_run && rst_n |=> reg_rvalid)
    else $error("read not answered");
  stray_answer_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  upper_wr_a: assert property (reg_wr && reg_addr == PIN_IO_CONTROL_OFF
    |-> reg_wdata[7:4] == UPPER_ZERO)
    else $error("upper pin bits written nonzero");
  upper_rd_a: assert property (reg_rvalid && $past(reg_addr) == PIN_IO_CONTROL_OFF
    |-> reg_rdata[7:4] == UPPER_ZERO)
    else $error("upper pin bits read nonzero");
  strobe_gap_a: assert property (reg_wr || reg_rd |=> !reg_wr && !reg_rd)
    else $error("strobes too close");

  // Main scenarios seen
  cover property ($fell(rst_n) && clk_run);
  cover property (reg_rvalid);
  cover property (reg_wr && reg_addr == PIN_IO_CONTROL_OFF);
endmodule // agp_link_checker

// file: verification/testbench.sv
`timescale 1ns/10ps
// Drives the controller over AHB-Lite and watches the converter pins
module testbench;
  import agp_pkg::*;
  localparam int POR = 16;
  localparam int RST = 4;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        supply_ok = 1'b0;
  logic        resp_mode = 1'b0;
  logic [1:0]  ext = 2'h2;
  logic [1:0]  pin_in;
  logic [1:0]  pin_out;
  logic [1:0]  pin_oe;
  logic [7:0]  cfg_seen = 8'h0;
  logic [31:0] d;
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc = 0;

  agp_link_if link();

  // Clock
  always #2 hclk = ~hclk;
  // Pin level: a driving end wins over the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

  agp_host #(.POR_CYCLES(POR), .RST_CYCLES(RST)) agp_host_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .supply_ok(supply_ok), .link(link));
  agp_dev agp_dev_inst (.hclk(hclk), .hresetn(hresetn), .link(link), .resp_mode(resp_mode),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  agp_link_checker #(.POR_CYCLES(POR), .RST_CYCLES(RST)) agp_link_checker_inst (
    .hclk(hclk), .hresetn(hresetn), .clk_run(link.clk_run), .rst_n(link.rst_n),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .reg_rvalid(link.reg_rvalid));

  // Captures the config value sent after reset
  always @(posedge hclk)
    if (link.reg_wr && link.reg_addr == CONFIG1_OFF)
      cfg_seen <= link.reg_wdata;

  // Hang guard
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt = error_cnt + 1;
      final_report();
    end
  end

  task final_report;
    begin
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("Error %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask

  // One single word transfer, entered just after a rising edge
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    begin
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      d = hrdata;
    end
  endtask

  // Reads status until one bit shows a value
  task poll(input int b, input logic v);
    int n;
    begin
      n = 0;
      do
      begin
        ahb(1'b0, HOST_STAT_OFF, 32'h0);
        n = n + 1;
      end
      while (d[b] !== v && n < 100);
      // A status bit that never settles counts as a mismatch
      if (d[b] !== v)
      begin
        error_cnt = error_cnt + 1;
        $display("Error %0t: status bit %0d never settled", $time, b);
      end
    end
  endtask

  // One converter register command, waits until it is done
  task dev(input logic w, input logic [7:0] v);
    begin
      ahb(1'b1, HOST_CMD_OFF, {15'h0, w, PIN_IO_CONTROL_OFF, v});
      repeat (4) @(posedge hclk);
      poll(STAT_BUSY_BIT, 1'b0);
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b1, HOST_CTRL_OFF, 32'ha501);
    repeat (30) @(posedge hclk);
    chk(link.clk_run, 1'b0);
    supply_ok <= 1'b1;
    poll(STAT_READY_BIT, 1'b1);
    chk(d & 32'h5, 32'h5);
    // Ready shows in the config write cycle; let the capture settle
    @(posedge hclk);
    chk(cfg_seen, 8'ha5);
    $display("power-up test done");
    dev(1'b0, 8'h0);
    chk(d[15:8], 8'h0e);
    chk(pin_oe, 2'h0);
    dev(1'b1, 8'hf1);
    chk(pin_oe, 2'h3);
    chk(pin_out, 2'h1);
    dev(1'b0, 8'h0);
    chk(d[15:8], 8'h01);
    ext <= 2'h0;
    dev(1'b1, 8'h0a);
    chk(pin_oe, 2'h1);
    chk(pin_out, 2'h0);
    dev(1'b0, 8'h0);
    chk(d[15:8], 8'h08);
    $display("pin test done");
    resp_mode <= 1'b1;
    repeat (5) @(posedge hclk);
    chk(pin_oe, 2'h0);
    resp_mode <= 1'b0;
    repeat (5) @(posedge hclk);
    chk(pin_oe, 2'h1);
    ahb(1'b0, 8'h10, 32'h0);
    chk(d, 32'h0);
    $display("takeover test done");
    ahb(1'b1, HOST_CTRL_OFF, 32'h0);
    repeat (3) @(posedge hclk);
    chk(link.rst_n, 1'b0);
    ahb(1'b1, HOST_CTRL_OFF, 32'h3c01);
    poll(STAT_READY_BIT, 1'b1);
    @(posedge hclk);
    chk(cfg_seen, 8'h3c);
    dev(1'b0, 8'h0);
    chk(d[15:8], 8'h0c);
    $display("restart test done");
    final_report();
  end
endmodule // testbench
